//--- eapsc_enable_config.sv
`timescale 1ns/1ps
// How it works
// - Controller stays off until all rails and enable pin good and timeout expired.
// - Controller turns off on the fifth clock after any rail or enable pin drops for two cycles or more.
// - Serial-bus commands are refused until the rails timeout has expired.
// - On/off configuration picks operation command, enable pin, or both as source; enable pin must be high in every case.
// - First strap byte, all eight bits, is the boot voltage code.
// - Second strap bit 7 picks pulse-frequency mode or forced PWM.
// - Second strap bits 6:5 pick temperature compensation off, +5, +15, +30.
// - Second strap bits 4:0 pick one of 32 bus addresses.
// - Third strap bit 7 enables ultrasonic pulse skipping, 25kHz clamp.
// - Third strap bit 6 picks latched overcurrent shutdown or 9ms retries.
// - Third strap bits 5:3 are the switching frequency code.
// - Third strap bits 2:0 are the error amplifier gain code.
// - Fourth strap bits 7:5 are the soft-start and voltage ramp rate.
// - Fourth strap bits 4:3 are the loop impedance selection.
// - Fourth strap bit 2 picks gain multiplier; bits 1:0 ignored.
// - Strap bytes are readable through commands DC to DF.
module eapsc_enable_config
  import eapsc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic highBiasRailOk, // High bias rail above threshold, pin
  input wire logic driverBiasRailOk, // Driver bias rail above threshold, pin
  input wire logic vccRailOk, // Core bias rail above threshold, pin
  input wire logic inputSupplyRailOk, // Input supply above threshold, pin
  input wire logic enablePinOk, // Enable pin above threshold, pin
  input wire logic strapValid, // Strap bytes valid from resistor reader
  input wire logic [7:0] strapBoot, // First strap byte
  input wire logic [7:0] strapMode, // Second strap byte
  input wire logic [7:0] strapFreq, // Third strap byte
  input wire logic [7:0] strapRamp, // Fourth strap byte
  input wire logic cmdStrobe, // Command request, one cycle
  input wire logic cmdWrite, // 1 write, 0 read
  input wire logic [7:0] cmdCode, // Command code
  input wire logic [7:0] cmdWData, // Write data
  output logic rspValid, // Answer valid, one cycle
  output logic rspAck, // Command accepted
  output logic [7:0] rspData, // Read data, zero when refused
  output logic busAccessible, // Serial bus open
  output logic strapsCaptured, // Straps held
  output logic controllerEnable, // Controller enable
  output logic [7:0] bootVoltageCode, // Boot voltage code
  output logic pulseFreqMode, // 1 pulse-frequency mode, 0 forced PWM
  output logic [1:0] tempCompSel, // Temperature compensation select
  output logic [4:0] busAddress, // Serial-bus address select
  output logic ultrasonicPulseSkip, // Ultrasonic pulse skip enable
  output logic ocpRetry, // 1 retry every 9ms, 0 latch off
  output logic [2:0] switchFrequencySelect, // Switching frequency code
  output logic [2:0] errorAmpGain, // Error amplifier gain code
  output logic [2:0] rampRateSel, // Ramp rate code
  output logic [1:0] loopImpedanceSelect, // Loop impedance code
  output logic gainMultiplierSelect // 0 gain 1x, 1 gain 2x
);

  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  generate
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > TIMEOUT_MAX_CYC) begin : g_bad
      $error("eapsc_enable_config: TIMEOUT_CYCLES out of range");
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Pin detection synchronisers
  // -------------------------------------------------------------------------
  logic [DET_COUNT-1:0] detRaw;
  logic [DET_COUNT-1:0] detSync1;
  logic [DET_COUNT-1:0] detSync2;
  logic [DET_COUNT-1:0] detSync3;
  logic [DET_COUNT-1:0] detStable;

  assign detRaw = {enablePinOk, inputSupplyRailOk, vccRailOk,
                   driverBiasRailOk, highBiasRailOk};

  generate
    for (genvar i = 0; i < DET_COUNT; i++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (srst) begin
          detSync1[i] <= 1'b0;
          detSync2[i] <= 1'b0;
          detSync3[i] <= 1'b0;
          detStable[i] <= 1'b0;
        end else if (ce) begin
          detSync1[i] <= detRaw[i];
          detSync2[i] <= detSync1[i];
          detSync3[i] <= detSync2[i];
          if (detSync2[i] == detSync3[i]) begin
            detStable[i] <= detSync3[i];
          end
        end
      end
    end
  endgenerate

  logic railsGood;
  logic enPinLevel;

  assign railsGood = (detStable[DET_EN-1:0] == RAILS_ALL);
  assign enPinLevel = detStable[DET_EN];

  // -------------------------------------------------------------------------
  // Power-on sequencing and timeout
  // -------------------------------------------------------------------------
  eapsc_power_t powerState;
  logic [CNT_W-1:0] timeoutCount;

  always_ff @(posedge mclk) begin
    if (srst) begin
      powerState <= PS_NO_RAILS;
      timeoutCount <= CNT_ZERO;
    end else if (ce) begin
      case (powerState)
        PS_NO_RAILS: begin
          timeoutCount <= CNT_ZERO;
          if (railsGood) begin
            powerState <= PS_TIMING;
          end
        end
        PS_TIMING: begin
          if (!railsGood) begin
            powerState <= PS_NO_RAILS;
          end else if (timeoutCount == CNT_LAST) begin
            powerState <= PS_READY;
          end else begin
            timeoutCount <= timeoutCount + CNT_ONE;
          end
        end
        PS_READY: begin
          if (!railsGood) begin
            powerState <= PS_NO_RAILS;
          end
        end
        default: begin
          powerState <= PS_NO_RAILS;
        end
      endcase
    end
  end

  logic next_busAccessible;

  assign next_busAccessible = (powerState == PS_READY) && railsGood;

  always_ff @(posedge mclk) begin
    if (srst) begin
      busAccessible <= 1'b0;
    end else if (ce) begin
      busAccessible <= next_busAccessible;
    end
  end

  // -------------------------------------------------------------------------
  // Strap capture and decode
  // -------------------------------------------------------------------------
  logic captureNow;

  assign captureNow = strapValid && !strapsCaptured;

  always_ff @(posedge mclk) begin
    if (srst) begin
      strapsCaptured <= 1'b0;
    end else if (ce && captureNow) begin
      strapsCaptured <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bootVoltageCode <= 8'h00;
      pulseFreqMode <= 1'b0;
      tempCompSel <= 2'h0;
      busAddress <= 5'h00;
    end else if (ce && captureNow) begin
      bootVoltageCode <= strapBoot[BOOT_MSB:BOOT_LSB];
      pulseFreqMode <= strapMode[PFM_BIT];
      tempCompSel <= strapMode[TCOMP_MSB:TCOMP_LSB];
      busAddress <= strapMode[ADDR_MSB:ADDR_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ultrasonicPulseSkip <= 1'b0;
      ocpRetry <= 1'b0;
      switchFrequencySelect <= 3'h0;
      errorAmpGain <= 3'h0;
    end else if (ce && captureNow) begin
      ultrasonicPulseSkip <= strapFreq[ULTRASONIC_PULSE_SKIP_BIT];
      ocpRetry <= strapFreq[FAULT_BIT];
      switchFrequencySelect <= strapFreq[FSW_MSB:FSW_LSB];
      errorAmpGain <= strapFreq[GAIN_MSB:GAIN_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rampRateSel <= 3'h0;
      loopImpedanceSelect <= 2'h0;
      gainMultiplierSelect <= 1'b0;
    end else if (ce && captureNow) begin
      rampRateSel <= strapRamp[RAMP_MSB:RAMP_LSB];
      loopImpedanceSelect <= strapRamp[LOOPZ_MSB:LOOPZ_LSB];
      gainMultiplierSelect <= strapRamp[MULT_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // Strap readback store
  // -------------------------------------------------------------------------
  logic [STRAP_COUNT*STRAP_WIDTH-1:0] strapAll;
  logic [1:0] strapRdIdx;
  logic [7:0] strapRdData;

  assign strapAll = {strapRamp, strapFreq, strapMode, strapBoot};
  assign strapRdIdx = cmdCode[1:0];

  eapsc_strap_store #(
    .DEPTH(STRAP_COUNT),
    .WIDTH(STRAP_WIDTH)
  ) u_store (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .allWrEn(captureNow),
    .allWrData(strapAll),
    .rdAddr(strapRdIdx),
    .rdData(strapRdData)
  );

  // -------------------------------------------------------------------------
  // Command decode
  // -------------------------------------------------------------------------
  logic [7:0] onOffConfig;
  logic [7:0] operation;
  logic isOperation;
  logic isOnOff;
  logic isStrap;
  logic cmdOk;

  assign isOperation = (cmdCode == CMD_OPERATION);
  assign isOnOff = (cmdCode == CMD_ON_OFF_CONFIG);
  assign isStrap = (cmdCode >= CMD_STRAP_FIRST) &&
                   (cmdCode <= CMD_STRAP_LAST);
  assign cmdOk = busAccessible &&
                 (isOperation || isOnOff || (isStrap && !cmdWrite));

  always_ff @(posedge mclk) begin
    if (srst) begin
      onOffConfig <= ONOFF_RESET;
      operation <= OPERATION_RESET;
    end else if (ce && cmdStrobe && cmdOk && cmdWrite) begin
      if (isOnOff) begin
        onOffConfig <= cmdWData;
      end
      if (isOperation) begin
        operation <= cmdWData;
      end
    end
  end

  // Answer pipeline: strap reads wait one cycle for the store
  logic pendValid;
  logic pendAck;
  logic pendStrap;
  logic [7:0] pendData;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pendValid <= 1'b0;
      pendAck <= 1'b0;
      pendStrap <= 1'b0;
      pendData <= 8'h00;
    end else if (ce) begin
      pendValid <= cmdStrobe;
      pendAck <= cmdStrobe && cmdOk;
      pendStrap <= cmdStrobe && cmdOk && isStrap;
      if (cmdStrobe && cmdOk && !cmdWrite && isOnOff) begin
        pendData <= onOffConfig;
      end else if (cmdStrobe && cmdOk && !cmdWrite && isOperation) begin
        pendData <= operation;
      end else begin
        pendData <= 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rspValid <= 1'b0;
      rspAck <= 1'b0;
      rspData <= 8'h00;
    end else if (ce) begin
      rspValid <= pendValid;
      rspAck <= pendAck;
      rspData <= pendStrap ? strapRdData : pendData;
    end
  end

  // -------------------------------------------------------------------------
  // Controller enable
  // -------------------------------------------------------------------------
  logic pinActive;
  logic pinTerm;
  logic cmdTerm;
  logic next_controllerEnable;

  assign pinActive = onOffConfig[ONOFF_POL_BIT] ? enPinLevel : !enPinLevel;

  // With neither source chosen the enable pin alone controls
  always_comb begin
    pinTerm = pinActive;
    cmdTerm = 1'b1;
    if (onOffConfig[ONOFF_PU_BIT]) begin
      if (onOffConfig[ONOFF_CMD_BIT]) begin
        cmdTerm = operation[OP_ON_BIT];
      end
      if (!onOffConfig[ONOFF_PIN_BIT] && onOffConfig[ONOFF_CMD_BIT]) begin
        pinTerm = 1'b1;
      end
    end
  end

  assign next_controllerEnable = (powerState == PS_READY) && railsGood &&
                                 strapsCaptured && enPinLevel &&
                                 pinTerm && cmdTerm;

  always_ff @(posedge mclk) begin
    if (srst) begin
      controllerEnable <= 1'b0;
    end else if (ce) begin
      controllerEnable <= next_controllerEnable;
    end
  end

endmodule

//--- eapsc_enable_config_assertions.sv
`timescale 1ns/1ps
module eapsc_checker
  import eapsc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic mclk, // Clock
  input wire logic srst, // Reset
  input wire logic highBiasRailOk, // Rail
  input wire logic driverBiasRailOk, // Rail
  input wire logic vccRailOk, // Rail
  input wire logic inputSupplyRailOk, // Rail
  input wire logic enablePinOk, // Enable pin
  input wire logic strapValid, // Strap valid
  input wire logic [7:0] strapBoot, // Strap byte
  input wire logic [7:0] strapMode, // Strap byte
  input wire logic [7:0] strapFreq, // Strap byte
  input wire logic [7:0] strapRamp, // Strap byte
  input wire logic cmdStrobe, // Request
  input wire logic cmdWrite, // Write
  input wire logic [7:0] cmdCode, // Code
  input wire logic rspValid, // Answer
  input wire logic rspAck, // Accepted
  input wire logic [7:0] rspData, // Read data
  input wire logic busAccessible, // Bus open
  input wire logic strapsCaptured, // Straps held
  input wire logic controllerEnable, // Enable
  input wire logic [7:0] bootVoltageCode, // Field
  input wire logic pulseFreqMode, // Field
  input wire logic [1:0] tempCompSel, // Field
  input wire logic [4:0] busAddress, // Field
  input wire logic ultrasonicPulseSkip, // Field
  input wire logic ocpRetry, // Field
  input wire logic [2:0] switchFrequencySelect, // Field
  input wire logic [2:0] errorAmpGain, // Field
  input wire logic [2:0] rampRateSel, // Field
  input wire logic [1:0] loopImpedanceSelect, // Field
  input wire logic gainMultiplierSelect // Field
);
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  logic [17:0] railCnt;
  logic allRails;
  logic [31:0] fields;
  assign allRails = highBiasRailOk & driverBiasRailOk & vccRailOk
    & inputSupplyRailOk;
  assign fields = {bootVoltageCode, pulseFreqMode, tempCompSel,
    busAddress, ultrasonicPulseSkip, ocpRetry, switchFrequencySelect,
    errorAmpGain, rampRateSel, loopImpedanceSelect, gainMultiplierSelect,
    2'h0};
  // Cycles the rails have been high without a break, saturating
  always_ff @(posedge mclk) begin
    if (srst || !allRails) begin
      railCnt <= 18'h00000;
    end else if (railCnt <= 18'(TIMEOUT_CYCLES + 16)) begin
      railCnt <= railCnt + 18'h00001;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_strapWrite;
    cmdStrobe && cmdWrite && cmdCode >= CMD_STRAP_FIRST
      && cmdCode <= CMD_STRAP_LAST;
  endsequence
  sequence s_pinLow;
    !enablePinOk [*7];
  endsequence
  sequence s_bootRead;
    cmdStrobe && !cmdWrite && cmdCode == CMD_STRAP_FIRST && busAccessible;
  endsequence
  a_resp_latency: assert property (cmdStrobe |-> ##2 rspValid)
    else $error("answer not two cycles after request");
  a_closed_nack: assert property (cmdStrobe && !busAccessible |->
    ##2 (!rspAck && rspData == 8'h00))
    else $error("request accepted while bus closed");
  a_strap_write: assert property (s_strapWrite |-> ##2 !rspAck)
    else $error("write to strap byte accepted");
  a_boot_readback: assert property (s_bootRead |->
    ##2 (rspAck && rspData == bootVoltageCode))
    else $error("boot strap read back wrong");
  a_pin_drop: assert property (s_pinLow |-> !controllerEnable)
    else $error("enable stayed on with pin low");
  a_bus_early: assert property (busAccessible && allRails |->
    railCnt > 18'(TIMEOUT_CYCLES))
    else $error("bus open before timeout");
  a_bus_late: assert property (railCnt == 18'(TIMEOUT_CYCLES + 10) |->
    busAccessible)
    else $error("bus not open after timeout");
  a_enable_rise: assert property ($rose(controllerEnable) |->
    busAccessible && strapsCaptured && railCnt > 18'(TIMEOUT_CYCLES))
    else $error("enable rose too early");
  a_capture_map: assert property (strapValid && !strapsCaptured |=>
    fields == {$past(strapBoot), $past(strapMode), $past(strapFreq),
      $past(strapRamp[7:2]), 2'h0})
    else $error("strap fields mismatch at capture");
  a_strap_hold: assert property (strapsCaptured |=>
    strapsCaptured && $stable(fields))
    else $error("strap fields changed after capture");
endmodule

bind eapsc_enable_config eapsc_checker #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_chk (
  .mclk, .srst, .highBiasRailOk, .driverBiasRailOk, .vccRailOk,
  .inputSupplyRailOk, .enablePinOk, .strapValid, .strapBoot, .strapMode,
  .strapFreq, .strapRamp, .cmdStrobe, .cmdWrite, .cmdCode, .rspValid,
  .rspAck, .rspData, .busAccessible, .strapsCaptured, .controllerEnable,
  .bootVoltageCode, .pulseFreqMode, .tempCompSel, .busAddress,
  .ultrasonicPulseSkip, .ocpRetry, .switchFrequencySelect, .errorAmpGain,
  .rampRateSel, .loopImpedanceSelect, .gainMultiplierSelect
);

//--- eapsc_enable_config_tb.sv
`timescale 1ns/1ps
module eapsc_enable_config_tb;
  import eapsc_pkg::*;
  localparam int TOC = 20;
  localparam logic [31:0] STRAPS = 32'hA5C96BE7;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic hbOk = 1'b1, dbOk = 1'b1, vcOk = 1'b1, isOk = 1'b1, enOk = 1'b1;
  logic cmdStrobe = 1'b0, cmdWrite = 1'b0;
  logic [7:0] cmdCode = 8'h00, cmdWData = 8'h00;
  logic strapValid, rspValid, rspAck, busAccessible, strapsCaptured;
  logic controllerEnable, pulseFreqMode, ultrasonicPulseSkip, ocpRetry;
  logic gainMultiplierSelect;
  logic [7:0] strapBoot, strapMode, strapFreq, strapRamp, rspData;
  logic [7:0] bootVoltageCode;
  logic [1:0] tempCompSel, loopImpedanceSelect;
  logic [4:0] busAddress;
  logic [2:0] switchFrequencySelect, errorAmpGain, rampRateSel;
  int errTotal = 0;
  int totalChecks = 0;
  always #20 mclk = ~mclk;
  eapsc_strap_model #(.STRAPS(STRAPS)) u_model (.mclk, .srst, .strapValid,
    .strapBoot, .strapMode, .strapFreq, .strapRamp);
  eapsc_enable_config #(.TIMEOUT_CYCLES(TOC)) DUT (.mclk, .srst, .ce,
    .highBiasRailOk(hbOk), .driverBiasRailOk(dbOk), .vccRailOk(vcOk),
    .inputSupplyRailOk(isOk), .enablePinOk(enOk), .strapValid,
    .strapBoot, .strapMode, .strapFreq, .strapRamp, .cmdStrobe, .cmdWrite,
    .cmdCode, .cmdWData, .rspValid, .rspAck, .rspData, .busAccessible,
    .strapsCaptured, .controllerEnable, .bootVoltageCode, .pulseFreqMode,
    .tempCompSel, .busAddress, .ultrasonicPulseSkip, .ocpRetry,
    .switchFrequencySelect, .errorAmpGain, .rampRateSel,
    .loopImpedanceSelect, .gainMultiplierSelect);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic endSim;
    $display("Checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One command, then the answer compared with ack and data expected
  task automatic cmd(input logic wr, input logic [7:0] code,
    input logic [7:0] wd, input logic ack, input logic [7:0] rd);
    int n;
    cmdStrobe = 1'b1;
    cmdWrite = wr;
    cmdCode = code;
    cmdWData = wd;
    @(posedge mclk);
    #1;
    cmdStrobe = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check({22'h0, rspValid, rspAck, rspData}, {22'h0, 1'b1, ack, rd});
    @(posedge mclk);
    #1;
  endtask
  // Waits a bounded time for enable (sel 0) or bus open (sel 1)
  task automatic waitSig(input logic sel, input logic exp, input int lim);
    int n;
    n = 0;
    while ((sel ? busAccessible : controllerEnable) !== exp && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    check({31'h0, sel ? busAccessible : controllerEnable}, {31'h0, exp});
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    srst = 1'b0;
    cmd(1'b0, CMD_STRAP_FIRST, 8'h00, 1'b0, 8'h00);
    waitSig(1'b1, 1'b1, TOC + 20);
    check({31'h0, strapsCaptured}, 32'h1);
    check({24'h0, bootVoltageCode}, {24'h0, STRAPS[31:24]});
    check({31'h0, pulseFreqMode}, {31'h0, STRAPS[23]});
    check({30'h0, tempCompSel}, {30'h0, STRAPS[22:21]});
    check({27'h0, busAddress}, {27'h0, STRAPS[20:16]});
    check({30'h0, ultrasonicPulseSkip, ocpRetry},
      {30'h0, STRAPS[15:14]});
    check({26'h0, switchFrequencySelect, errorAmpGain},
      {26'h0, STRAPS[13:8]});
    check({27'h0, rampRateSel, loopImpedanceSelect},
      {27'h0, STRAPS[7:3]});
    check({31'h0, gainMultiplierSelect}, {31'h0, STRAPS[2]});
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, CMD_STRAP_FIRST + 8'(i), 8'h00, 1'b1,
        STRAPS[31 - 8 * i -: 8]);
    end
    cmd(1'b1, CMD_STRAP_LAST, 8'h3C, 1'b0, 8'h00);
    cmd(1'b0, CMD_STRAP_LAST, 8'h00, 1'b1, STRAPS[7:0]);
    cmd(1'b0, 8'h55, 8'h00, 1'b0, 8'h00);
    cmd(1'b0, CMD_ON_OFF_CONFIG, 8'h00, 1'b1, ONOFF_RESET);
    cmd(1'b0, CMD_OPERATION, 8'h00, 1'b1, OPERATION_RESET);
    waitSig(1'b0, 1'b1, 12);
    cmd(1'b1, CMD_ON_OFF_CONFIG, 8'h1E, 1'b1, 8'h00);
    cmd(1'b0, CMD_ON_OFF_CONFIG, 8'h00, 1'b1, 8'h1E);
    waitSig(1'b0, 1'b0, 6);
    cmd(1'b1, CMD_OPERATION, 8'h80, 1'b1, 8'h00);
    waitSig(1'b0, 1'b1, 6);
    cmd(1'b1, CMD_OPERATION, 8'h00, 1'b1, 8'h00);
    waitSig(1'b0, 1'b0, 6);
    cmd(1'b1, CMD_ON_OFF_CONFIG, 8'h0E, 1'b1, 8'h00);
    waitSig(1'b0, 1'b1, 6);
    cmd(1'b1, CMD_ON_OFF_CONFIG, 8'h14, 1'b1, 8'h00);
    waitSig(1'b0, 1'b0, 6);
    cmd(1'b1, CMD_ON_OFF_CONFIG, ONOFF_RESET, 1'b1, 8'h00);
    waitSig(1'b0, 1'b1, 6);
    enOk = 1'b0;
    waitSig(1'b0, 1'b0, 8);
    enOk = 1'b1;
    waitSig(1'b0, 1'b1, 8);
    // Clock enable low freezes the pin chain, so a five-cycle drop is ignored
    ce = 1'b0;
    enOk = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    check({31'h0, controllerEnable}, 32'h1);
    ce = 1'b1;
    enOk = 1'b1;
    isOk = 1'b0;
    waitSig(1'b0, 1'b0, 8);
    waitSig(1'b1, 1'b0, 8);
    cmd(1'b0, CMD_STRAP_FIRST, 8'h00, 1'b0, 8'h00);
    isOk = 1'b1;
    repeat (TOC / 2) @(posedge mclk);
    #1;
    check({31'h0, controllerEnable}, 32'h0);
    waitSig(1'b0, 1'b1, TOC + 20);
    check({24'h0, bootVoltageCode}, {24'h0, STRAPS[31:24]});
    cmd(1'b0, CMD_STRAP_FIRST + 8'h01, 8'h00, 1'b1, STRAPS[23:16]);
    endSim();
  end
  initial begin
    #(40 * (20 * TOC + 600));
    errTotal++;
    $display("ERROR %0t: watchdog expired", $time);
    endSim();
  end
endmodule

//--- eapsc_pkg.sv
package eapsc_pkg;

  // -------------------------------------------------------------------------
  // Clock and timing
  // -------------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CLK_KHZ = CLK_HZ / 1000;
  // Start-up and bus-accessible timeout, typical and worst case, in us
  localparam int TIMEOUT_US = 5500;
  localparam int TIMEOUT_MAX_US = 6500;
  localparam int TIMEOUT_CYC = (TIMEOUT_US * CLK_KHZ) / 1000;
  localparam int TIMEOUT_MAX_CYC = (TIMEOUT_MAX_US * CLK_KHZ) / 1000;

  // -------------------------------------------------------------------------
  // Serial-bus command codes
  // -------------------------------------------------------------------------
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_STRAP_FIRST = 8'hDC;
  localparam logic [7:0] CMD_STRAP_LAST = 8'hDF;

  // -------------------------------------------------------------------------
  // On/off configuration and operation fields
  // -------------------------------------------------------------------------
  localparam int ONOFF_PU_BIT = 4;
  localparam int ONOFF_CMD_BIT = 3;
  localparam int ONOFF_PIN_BIT = 2;
  localparam int ONOFF_POL_BIT = 1;
  localparam int OP_ON_BIT = 7;
  localparam logic [7:0] ONOFF_RESET = 8'h16;
  localparam logic [7:0] OPERATION_RESET = 8'h00;

  // -------------------------------------------------------------------------
  // Strap byte indices and field positions
  // -------------------------------------------------------------------------
  localparam int STRAP_COUNT = 4;
  localparam int STRAP_WIDTH = 8;
  localparam logic [1:0] STRAP_BOOT = 2'h0;
  localparam logic [1:0] STRAP_MODE = 2'h1;
  localparam logic [1:0] STRAP_FREQ = 2'h2;
  localparam logic [1:0] STRAP_RAMP = 2'h3;
  localparam int BOOT_MSB = 7;
  localparam int BOOT_LSB = 0;
  localparam int PFM_BIT = 7;
  localparam int TCOMP_MSB = 6;
  localparam int TCOMP_LSB = 5;
  localparam int ADDR_MSB = 4;
  localparam int ADDR_LSB = 0;
  localparam int ULTRASONIC_PULSE_SKIP_BIT = 7;
  localparam int FAULT_BIT = 6;
  localparam int FSW_MSB = 5;
  localparam int FSW_LSB = 3;
  localparam int GAIN_MSB = 2;
  localparam int GAIN_LSB = 0;
  localparam int RAMP_MSB = 7;
  localparam int RAMP_LSB = 5;
  localparam int LOOPZ_MSB = 4;
  localparam int LOOPZ_LSB = 3;
  localparam int MULT_BIT = 2;

  // -------------------------------------------------------------------------
  // Detections: four rails and the enable pin
  // -------------------------------------------------------------------------
  localparam int DET_COUNT = 5;
  localparam int DET_EN = 4;
  localparam logic [DET_COUNT-1:0] DET_NONE = 5'h00;
  localparam logic [3:0] RAILS_ALL = 4'hF;

  typedef enum logic [1:0] {
    PS_NO_RAILS,
    PS_TIMING,
    PS_READY
  } eapsc_power_t;

endpackage

//--- eapsc_strap_model.sv
`timescale 1ns/1ps
module eapsc_strap_model #(
  parameter logic [31:0] STRAPS = 32'h00000000,
  parameter logic [7:0] FIRST_AT = 8'h08,
  parameter logic [7:0] SECOND_AT = 8'h28
) (
  input wire logic mclk, // Clock
  input wire logic srst, // Reset
  output logic strapValid, // Bytes valid
  output logic [7:0] strapBoot, // Byte 1
  output logic [7:0] strapMode, // Byte 2
  output logic [7:0] strapFreq, // Byte 3
  output logic [7:0] strapRamp // Byte 4
);
  logic [7:0] cnt;
  logic first;
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end
  // Second conversion brings other values; it must be ignored
  assign first = (cnt == FIRST_AT);
  assign strapValid = first || (cnt == SECOND_AT);
  // Outside the first valid cycle the bytes change every second cycle until the count stops at FF
  assign {strapBoot, strapMode, strapFreq, strapRamp} = first ? STRAPS
    : STRAPS ^ {4{cnt | 8'h01}};
endmodule

//--- eapsc_strap_store.sv
`timescale 1ns/1ps
module eapsc_strap_store #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 8
) (
  input wire logic mclk, // Clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic allWrEn, // Write every entry at once
  input wire logic [DEPTH*WIDTH-1:0] allWrData, // Entry i in slice i
  input wire logic [$clog2(DEPTH)-1:0] rdAddr, // Read index
  output logic [WIDTH-1:0] rdData // Registered read data
);

  // -------------------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("eapsc_strap_store: DEPTH must be 2 or more");
    end
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge mclk) begin
        if (srst) begin
          mem[i] <= '0;
        end else if (ce && allWrEn) begin
          mem[i] <= allWrData[i*WIDTH +: WIDTH];
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData <= '0;
    end else if (ce) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule
